// >>> sim/prcp_checker.sv
`timescale 1ns/1ns
module prcp_checker #(
   parameter ROM_AW = 11
) (
   // Clock and reset
   input wire logic              hclk,
   input wire logic              hresetn,
   // CPU side
   input wire logic              irq_take,
   input wire logic [ROM_AW-1:0] pc_current,
   input wire logic              cpu_hold_q,
   input wire logic              pc_load_q,
   input wire logic [ROM_AW-1:0] pc_load_val_q,
   input wire logic              stack_push_q,
   input wire logic [ROM_AW-1:0] stack_push_pc_q,
   // Options and shared pin
   input wire logic [13:0]       config_word_high,
   input wire logic              ext_pin_reset_enable,
   input wire logic [1:0]        low_voltage_reset,
   input wire logic              lvd_flag_enable,
   input wire logic              watchdog_reset_enable,
   input wire logic              watchdog_idle_stop_q,
   input wire logic              port_a_bit7,
   input wire logic              ext_reset_req_q,
   input wire logic              port_a_bit7_gpio_q
);
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   sequence s_held;
      cpu_hold_q [*3];
   endsequence
   sequence s_run;
      !cpu_hold_q;
   endsequence
   property p_boot;
      $rose(hresetn) |-> s_held ##1 s_run;
   endproperty
   a_boot: assert property (p_boot)
      else $error("core not released on third edge");
   property p_vec;
      $fell(cpu_hold_q) |-> $past(pc_load_q) && $past(pc_load_val_q) == '0;
   endproperty
   a_vec: assert property (p_vec)
      else $error("no load of zero before run");
   property p_irq;
      irq_take && !cpu_hold_q |=> stack_push_q && pc_load_q
         && pc_load_val_q == 4
         && stack_push_pc_q == $past(pc_current);
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt entry wrong");
   // Options may only move with a reset, never under a running core
   property p_hold;
      !cpu_hold_q |=> !cpu_hold_q && $stable(config_word_high);
   endproperty
   a_hold: assert property (p_hold)
      else $error("options moved while running");
   property p_lvr;
      !cpu_hold_q |-> low_voltage_reset == config_word_high[11:10]
         && lvd_flag_enable == (config_word_high[11:10] == 2'b00);
   endproperty
   a_lvr: assert property (p_lvr)
      else $error("low voltage option wrong");
   property p_wdt;
      !cpu_hold_q |-> watchdog_reset_enable == config_word_high[9]
         && watchdog_idle_stop_q == (config_word_high[9:8] == 2'b10);
   endproperty
   a_wdt: assert property (p_wdt)
      else $error("watchdog option wrong");
   property p_pin_on;
      !cpu_hold_q && ext_pin_reset_enable && config_word_high[12] |=>
         ext_reset_req_q == !$past(port_a_bit7) && port_a_bit7_gpio_q;
   endproperty
   a_pin_on: assert property (p_pin_on)
      else $error("pin reset path wrong");
   property p_pin_off;
      !cpu_hold_q && !ext_pin_reset_enable |=> !ext_reset_req_q
         && port_a_bit7_gpio_q == $past(port_a_bit7);
   endproperty
   a_pin_off: assert property (p_pin_off)
      else $error("pin not plain io");
endmodule

bind prcp_top prcp_checker #(.ROM_AW(ROM_AW)) u_chk (
   .hclk, .hresetn, .irq_take, .pc_current, .cpu_hold_q, .pc_load_q,
   .pc_load_val_q, .stack_push_q, .stack_push_pc_q, .config_word_high,
   .ext_pin_reset_enable, .low_voltage_reset, .lvd_flag_enable,
   .watchdog_reset_enable, .watchdog_idle_stop_q, .port_a_bit7,
   .ext_reset_req_q, .port_a_bit7_gpio_q);

// >>> sim/prcp_cpu_model.sv
`timescale 1ns/1ns
module prcp_cpu_model (
   // Clock and reset
   input  wire logic       hclk,
   input  wire logic       hresetn,
   // Bench request and core state
   input  wire logic       cpu_hold_q,
   input  wire logic       fire,
   input  wire logic [3:0] fire_pc,
   // Towards the block
   output logic            irq_take,
   output logic [3:0]      pc_current
);
   // A running core walks its PC, so pc_current never sits still
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_take   <= 1'b0;
         pc_current <= 4'h0;
      end else begin
         irq_take   <= fire & ~cpu_hold_q;
         pc_current <= fire ? fire_pc : pc_current + 4'h1;
      end
   end
endmodule

// >>> sim/test_program_rom_config_protect.sv
`timescale 1ns/1ns
`include "prcp_map.vh"
module test_program_rom_config_protect;
   logic        hclk = 1'b0, hresetn = 1'b0, por_n = 1'b0, hsel = 1'b1;
   logic        hwrite = 1'b0, prog_mode = 1'b1, pin = 1'b1, fire = 1'b0;
   logic [1:0]  htrans = 2'b00;
   logic [7:0]  haddr = 8'h00;
   logic [31:0] hwdata = 32'h0, rd;
   logic [3:0]  fire_pc = 4'h0, a, pc;
   logic [15:0] d;
   logic [13:0] cfg;
   wire  [31:0] hrdata;
   wire  [13:0] config_word_high;
   wire  [3:0]  pc_current, pc_load_val_q, stack_push_pc_q;
   wire  [1:0]  low_voltage_reset;
   wire         hreadyout, irq_take, cpu_hold_q, pc_load_q, stack_push_q;
   wire         ext_pin_reset_enable, lvd_flag_enable, watchdog_reset_enable;
   wire         watchdog_idle_stop_q, ext_reset_req_q, port_a_bit7_gpio_q;
   int          mismatches = 0, cmp_count = 0, seed = 48, i;

   prcp_top #(.ROM_WORDS(16), .ROM_AW(4)) u_dut (
      .hclk, .hresetn, .por_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize(3'b010), .hready(hreadyout), .hwdata, .hrdata, .hreadyout,
      .hresp(), .prog_mode, .irq_take, .pc_current, .cpu_hold_q,
      .pc_load_q, .pc_load_val_q, .stack_push_q, .stack_push_pc_q,
      .config_word_high, .ext_pin_reset_enable, .low_voltage_reset,
      .lvd_flag_enable, .watchdog_reset_enable, .watchdog_idle_stop_q,
      .port_a_bit7(pin), .ext_reset_req_q, .port_a_bit7_gpio_q);
   prcp_cpu_model u_cpu (.hclk, .hresetn, .cpu_hold_q, .fire, .fire_pc,
      .irq_take, .pc_current);

   initial begin
      forever #4 hclk = ~hclk;
   end
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task finish_test;
      $display("compares %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #200000;
      mismatches++;
      finish_test;
   end
   task step;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 40);
      if (n >= 40) begin
         mismatches++;
         finish_test;
      end
   endtask
   task bus(input logic w, input logic [7:0] ad, input logic [31:0] dt);
      haddr  <= ad;
      hwrite <= w;
      htrans <= 2'b10;
      step;
      htrans <= 2'b00;
      hwdata <= dt;
      step;
      rd = hrdata;
   endtask
   task rdb(input logic [7:0] ad);
      bus(1'b0, ad, 32'h0);
   endtask
   // Polls busy so a long erase never meets a refused command
   task cmd(input int b, input logic [3:0] ad, input logic [15:0] dt);
      int n;
      bus(1'b1, `PRCP_OFS_ADDR, {28'h0, ad});
      bus(1'b1, `PRCP_OFS_WDATA, {16'h0, dt});
      bus(1'b1, `PRCP_OFS_CMD, 32'h1 << b);
      n = 0;
      do begin
         rdb(`PRCP_OFS_STATUS);
         n++;
      end while (rd[`PRCP_ST_BUSY] !== 1'b0 && n < 40);
      if (n >= 40) begin
         mismatches++;
         finish_test;
      end
   endtask
   task refused(input logic e);
      rdb(`PRCP_OFS_STATUS);
      chk({31'h0, rd[`PRCP_ST_REFUSED]}, {31'h0, e});
      bus(1'b1, `PRCP_OFS_STATUS, 32'h2);
   endtask
   function logic [31:0] opt(input logic [13:0] c);
      return {26'h0, c[12], c[11:10], c[11:10] == 2'b00, c[9],
              c[9:8] == 2'b10};
   endfunction

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      por_n   <= 1'b1;
      repeat (4) @(posedge hclk);
      chk({18'h0, config_word_high}, 32'h0);
      cmd(`PRCP_CMD_ERASE, '0, '0);
      for (i = 0; i < 4; i++) begin
         a = 4'($random(seed));
         d = 16'($random(seed));
         cmd(`PRCP_CMD_WRITE, a, d);
         cmd(`PRCP_CMD_READ, a, '0);
         rdb(`PRCP_OFS_RDATA);
         chk(rd, {16'h0, d});
      end
      cfg = {1'b1, 13'($random(seed))};
      cmd(`PRCP_CMD_CFG_WR, '0, {2'b00, cfg});
      rdb(`PRCP_OFS_CFG);
      chk(rd, {18'h0, cfg});
      rdb(`PRCP_OFS_STATUS);
      chk({31'h0, rd[`PRCP_ST_PROTECT]}, 32'h1);
      cmd(`PRCP_CMD_READ, a + 4'h1, '0);
      rdb(`PRCP_OFS_RDATA);
      chk(rd, {16'h0, d});
      refused(1'b1);
      cmd(`PRCP_CMD_WRITE, a, ~d);
      refused(1'b1);
      cmd(`PRCP_CMD_CFG_WR, '0, {3'b000, cfg[12:0]});
      refused(1'b1);
      cmd(`PRCP_CMD_ERASE, '0, '0);
      rdb(`PRCP_OFS_CFG);
      chk(rd, {18'h0, cfg});
      prog_mode <= 1'b0;
      cmd(`PRCP_CMD_CFG_WR, '0, '0);
      prog_mode <= 1'b1;
      refused(1'b1);
      cmd(`PRCP_CMD_CFG_WR, '0, {3'b000, cfg[12:0]});
      refused(1'b0);
      cmd(`PRCP_CMD_READ, a, '0);
      rdb(`PRCP_OFS_RDATA);
      chk(rd, {16'h0, `PRCP_ERASED_WORD});
      $display("protection sequence done");
      for (i = 0; i < 4; i++) begin
         cfg = {1'b0, i[0], i[1:0], ~i[1:0], 8'($random(seed))};
         cmd(`PRCP_CMD_CFG_WR, '0, {2'b00, cfg});
         hresetn <= 1'b0;
         @(posedge hclk);
         hresetn <= 1'b1;
         repeat (5) @(posedge hclk);
         chk({26'h0, ext_pin_reset_enable, low_voltage_reset,
              lvd_flag_enable, watchdog_reset_enable,
              watchdog_idle_stop_q}, opt(cfg));
         pin <= 1'($random(seed));
         repeat (2) @(posedge hclk);
         chk({30'h0, ext_reset_req_q, port_a_bit7_gpio_q},
             {30'h0, i[0] & ~pin, i[0] | pin});
         pc = 4'($random(seed));
         fire    <= 1'b1;
         fire_pc <= pc;
         @(posedge hclk);
         fire <= 1'b0;
         @(posedge hclk);
         #1;
         chk({22'h0, stack_push_q, pc_load_q, stack_push_pc_q,
              pc_load_val_q}, {22'h0, 2'b11, pc, 4'h4});
         @(posedge hclk);
         $display("option set %0d done", i);
      end
      finish_test;
   end
endmodule

// >>> verilog/prcp_map.vh
`ifndef PRCP_MAP_VH
`define PRCP_MAP_VH

// Byte offsets of the programmer-side registers
`define PRCP_OFS_CMD        8'h00
`define PRCP_OFS_ADDR       8'h04
`define PRCP_OFS_WDATA      8'h08
`define PRCP_OFS_RDATA      8'h0c
`define PRCP_OFS_STATUS     8'h10
`define PRCP_OFS_CFG        8'h14

// Command register bits (write one to start)
`define PRCP_CMD_READ       0
`define PRCP_CMD_WRITE      1
`define PRCP_CMD_ERASE      2
`define PRCP_CMD_CFG_WR     3
`define PRCP_CMD_CFG_RD     4

// Status register bits
`define PRCP_ST_BUSY        0
`define PRCP_ST_REFUSED     1
`define PRCP_ST_PROTECT     2
`define PRCP_ST_ERASED      3
`define PRCP_ST_CPU_RUN     4

// Configuration word layout
`define PRCP_CFG_W          14
`define PRCP_CFG_RESET      14'h0000
`define PRCP_CFG_PROTECT    13
`define PRCP_CFG_EXT_PIN_RESET_ENABLE      12
`define PRCP_CFG_LVR_HI     11
`define PRCP_CFG_LVR_LO     10
`define PRCP_CFG_WDT_HI     9
`define PRCP_CFG_WDT_LO     8

// Index of the configuration word in the information area
`define PRCP_CONFIG_AREA_A_CFG_IDX   6'h00
`define PRCP_CONFIG_AREA_A_WORDS     64

// Fixed program counter targets
`define PRCP_RESET_VEC      11'h000
`define PRCP_IRQ_VEC        11'h004

// Value of a word after erase
`define PRCP_ERASED_WORD    16'hffff

`endif

// >>> verilog/prcp_top.v
// Functional notes
// - After reset, program counter loads 000h and registers return to defaults.
// - Taking an interrupt pushes the PC and jumps to 004h.
// - Configuration word lives in a separate information area, not program ROM.
// - Programmer reads user ROM only while protection bit is clear.
// - Configuration word stays readable whatever the protection bit.
// - Protection bit clears only after the user area was erased; here a power-on (por_n) also clears it, and user ROM is kept.
// - While protected, user ROM writes are blocked.
// - Config word is 13 bits plus protect, zero default, programmer-only writes.
// - Config bit 13 set enables code protection.
// - Config bit 12 set makes the shared pin an active-low reset.
// - Config bit 12 clear leaves the shared pin as plain GPIO.
// - Config bits 11..10 pick the low-voltage reset threshold.
// - Config bits 9..8 pick the watchdog reset mode.
//
// Local design decisions: register access over AHB-Lite and the address map.
`timescale 1ns/1ns
`include "prcp_map.vh"

module prcp_top #(
   parameter ROM_WORDS = 2048,
   parameter ROM_AW    = 11
) (
   // Clock and reset
   input  wire                  hclk,
   input  wire                  hresetn,
   input  wire                  por_n,
   // AHB-Lite slave, programmer side
   input  wire                  hsel,
   input  wire [7:0]            haddr,
   input  wire [1:0]            htrans,
   input  wire                  hwrite,
   input  wire [2:0]            hsize,
   input  wire                  hready,
   input  wire [31:0]           hwdata,
   output reg  [31:0]           hrdata,
   output reg                   hreadyout,
   output reg                   hresp,
   // Programmer presence strap
   input  wire                  prog_mode,
   // CPU core side
   input  wire                  irq_take,
   input  wire [ROM_AW-1:0]     pc_current,
   output reg                   cpu_hold_q,
   output reg                   pc_load_q,
   output reg  [ROM_AW-1:0]     pc_load_val_q,
   output reg                   stack_push_q,
   output reg  [ROM_AW-1:0]     stack_push_pc_q,
   // Option bits
   output reg  [`PRCP_CFG_W-1:0] config_word_high,
   output reg                   ext_pin_reset_enable,
   output reg  [1:0]            low_voltage_reset,
   output reg                   lvd_flag_enable,
   output reg                   watchdog_reset_enable,
   output reg                   watchdog_idle_stop_q,
   // Shared reset / GPIO pin
   input  wire                  port_a_bit7,
   output reg                   ext_reset_req_q,
   output reg                   port_a_bit7_gpio_q
);

   localparam [2:0] ST_LOAD  = 3'b001;
   localparam [2:0] ST_LATCH = 3'b010;
   localparam [2:0] ST_RUN   = 3'b100;

   // Fixed targets cut to the PC width actually built
   localparam [10:0] RST_VEC_FULL = `PRCP_RESET_VEC;
   localparam [10:0] IRQ_VEC_FULL = `PRCP_IRQ_VEC;

   // Program ROM array; flash contents survive any reset
   reg  [15:0]             rom_mem [0:ROM_WORDS-1];
   // Config word kept apart from the program words
   reg  [`PRCP_CFG_W-1:0]  cfg_flash_q;
   reg                     erased_q;

   reg  [2:0]              state_q;
   reg                     wr_pend_q;
   reg  [7:0]              wr_addr_q;
   reg  [ROM_AW-1:0]       addr_q;
   reg  [15:0]             wdata_q;
   reg  [15:0]             rdata_q;
   reg                     refused_q;
   reg                     busy_q;
   reg  [ROM_AW-1:0]       erase_cnt_q;
   reg                     rom_we;
   reg  [ROM_AW-1:0]       rom_waddr;
   reg  [15:0]             rom_wdata;

   wire                    addr_phase;
   wire                    cmd_wr;
   wire [4:0]              cmd;
   wire                    protect;
   wire                    refuse_rd;
   wire                    refuse_wr;
   wire                    refuse_cfg;
   wire                    refuse_busy;
   wire                    refuse_any;
   wire                    clr_refused;

   assign addr_phase = hsel & hready & htrans[1];
   assign cmd_wr     = wr_pend_q & (wr_addr_q == `PRCP_OFS_CMD);
   assign cmd        = hwdata[4:0];
   assign protect    = cfg_flash_q[`PRCP_CFG_PROTECT];
   assign refuse_busy = cmd_wr & busy_q & (|cmd);
   assign refuse_rd  = cmd_wr & ~busy_q & cmd[`PRCP_CMD_READ] &
                       protect;
   assign refuse_wr  = cmd_wr & ~busy_q &
                       (cmd[`PRCP_CMD_WRITE] & protect);
   // Dropping protection needs a fresh erase; writer must also be present
   assign refuse_cfg = cmd_wr & ~busy_q & cmd[`PRCP_CMD_CFG_WR] &
                       (~prog_mode |
                        (protect & ~wdata_q[`PRCP_CFG_PROTECT] &
                         ~erased_q));
   assign refuse_any = refuse_busy | refuse_rd | refuse_wr | refuse_cfg;
   assign clr_refused = wr_pend_q & (wr_addr_q == `PRCP_OFS_STATUS) &
                        hwdata[`PRCP_ST_REFUSED];

   // Bus slave: zero wait state, always OKAY
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata    <= 32'h0000_0000;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_q <= addr_phase & hwrite;
         if (addr_phase) begin
            wr_addr_q <= haddr;
         end
         if (addr_phase & ~hwrite) begin
            case (haddr)
               `PRCP_OFS_ADDR: begin
                  hrdata <= {{(32-ROM_AW){1'b0}}, addr_q};
               end
               `PRCP_OFS_WDATA: begin
                  hrdata <= {16'h0000, wdata_q};
               end
               `PRCP_OFS_RDATA: begin
                  hrdata <= {16'h0000, rdata_q};
               end
               `PRCP_OFS_STATUS: begin
                  hrdata <= {27'h0000000, (state_q == ST_RUN), erased_q,
                             protect, refused_q, busy_q};
               end
               `PRCP_OFS_CFG: begin
                  hrdata <= {18'h00000, cfg_flash_q};
               end
               default: begin
                  hrdata <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // Programmer-side address and data registers
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_q  <= {ROM_AW{1'b0}};
         wdata_q <= 16'h0000;
      end else if (wr_pend_q) begin
         if (wr_addr_q == `PRCP_OFS_ADDR) begin
            addr_q <= hwdata[ROM_AW-1:0];
         end
         if (wr_addr_q == `PRCP_OFS_WDATA) begin
            wdata_q <= hwdata[15:0];
         end
      end
   end

   // Flash command engine
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rdata_q     <= 16'h0000;
         refused_q   <= 1'b0;
         busy_q      <= 1'b0;
         erase_cnt_q <= {ROM_AW{1'b0}};
      end else begin
         // A new refusal wins over a clear in the same cycle
         refused_q <= refuse_any | (refused_q & ~clr_refused);
         if (busy_q) begin
            erase_cnt_q <= erase_cnt_q + {{(ROM_AW-1){1'b0}}, 1'b1};
            if (erase_cnt_q == ROM_WORDS[ROM_AW-1:0] - 1'b1) begin
               busy_q <= 1'b0;
            end
         end else if (cmd_wr & ~refuse_any) begin
            if (cmd[`PRCP_CMD_READ]) begin
               rdata_q <= rom_mem[addr_q];
            end else if (cmd[`PRCP_CMD_CFG_RD]) begin
               rdata_q <= {2'b00, cfg_flash_q};
            end
            if (cmd[`PRCP_CMD_ERASE]) begin
               busy_q      <= 1'b1;
               erase_cnt_q <= {ROM_AW{1'b0}};
            end
         end
      end
   end

   always @* begin
      rom_we    = 1'b0;
      rom_waddr = addr_q;
      rom_wdata = wdata_q;
      if (busy_q) begin
         rom_we    = 1'b1;
         rom_waddr = erase_cnt_q;
         rom_wdata = `PRCP_ERASED_WORD;
      end else if (cmd_wr & ~refuse_any & cmd[`PRCP_CMD_WRITE] &
                   ~cmd[`PRCP_CMD_ERASE]) begin
         rom_we = 1'b1;
      end
   end

   always @(posedge hclk) begin
      if (rom_we) begin
         rom_mem[rom_waddr] <= rom_wdata;
      end
   end

   // Nonvolatile state: only a power-on clears it, to the blank default
   always @(posedge hclk or negedge por_n) begin
      if (!por_n) begin
         cfg_flash_q <= `PRCP_CFG_RESET;
         erased_q    <= 1'b0;
      end else begin
         if (busy_q & (erase_cnt_q == ROM_WORDS[ROM_AW-1:0] - 1'b1)) begin
            erased_q <= 1'b1;
         end else if (rom_we) begin
            erased_q <= 1'b0;
         end
         // Only the programmer port reaches this word, never the CPU
         if (cmd_wr & ~refuse_any & ~busy_q & cmd[`PRCP_CMD_CFG_WR]) begin
            cfg_flash_q <= wdata_q[`PRCP_CFG_W-1:0];
         end
      end
   end

   // Reset sequence: fetch option word, latch it, then release the CPU
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_q               <= ST_LOAD;
         cpu_hold_q            <= 1'b1;
         pc_load_q             <= 1'b0;
         pc_load_val_q         <= RST_VEC_FULL[ROM_AW-1:0];
         stack_push_q          <= 1'b0;
         stack_push_pc_q       <= {ROM_AW{1'b0}};
         config_word_high      <= `PRCP_CFG_RESET;
         ext_pin_reset_enable  <= 1'b0;
         low_voltage_reset     <= 2'b00;
         lvd_flag_enable       <= 1'b0;
         watchdog_reset_enable <= 1'b0;
         watchdog_idle_stop_q  <= 1'b0;
      end else begin
         pc_load_q    <= 1'b0;
         stack_push_q <= 1'b0;
         case (state_q)
            ST_LOAD: begin
               config_word_high <= cfg_flash_q;
               state_q          <= ST_LATCH;
            end
            ST_LATCH: begin
               ext_pin_reset_enable <=
                  config_word_high[`PRCP_CFG_EXT_PIN_RESET_ENABLE];
               low_voltage_reset <=
                  config_word_high[`PRCP_CFG_LVR_HI:`PRCP_CFG_LVR_LO];
               lvd_flag_enable <=
                  ~|config_word_high[`PRCP_CFG_LVR_HI:`PRCP_CFG_LVR_LO];
               // 11 always on, 10 off in idle/stop, 0x off
               watchdog_reset_enable <= config_word_high[`PRCP_CFG_WDT_HI];
               watchdog_idle_stop_q  <= config_word_high[`PRCP_CFG_WDT_HI] &
                                        ~config_word_high[`PRCP_CFG_WDT_LO];
               pc_load_q     <= 1'b1;
               pc_load_val_q <= RST_VEC_FULL[ROM_AW-1:0];
               state_q       <= ST_RUN;
            end
            ST_RUN: begin
               cpu_hold_q <= 1'b0;
               if (irq_take & ~cpu_hold_q) begin
                  stack_push_q    <= 1'b1;
                  stack_push_pc_q <= pc_current;
                  pc_load_q       <= 1'b1;
                  pc_load_val_q   <= IRQ_VEC_FULL[ROM_AW-1:0];
               end
            end
            default: begin
               state_q <= ST_LOAD;
            end
         endcase
      end
   end

   // Threshold code 11:4.2V 10:3.6V 01:2.8V 00:2.2V with detect

   // Shared pin: reset input when enabled, otherwise plain GPIO
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ext_reset_req_q    <= 1'b0;
         port_a_bit7_gpio_q <= 1'b1;
      end else if (ext_pin_reset_enable) begin
         ext_reset_req_q    <= ~port_a_bit7;
         port_a_bit7_gpio_q <= 1'b1;
      end else begin
         ext_reset_req_q    <= 1'b0;
         port_a_bit7_gpio_q <= port_a_bit7;
      end
   end

endmodule
